// file: logic/mlf_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit register index port, 32-bit data, 100 MHz core clock
// Notes:   Definitions only
`ifndef MLF_CFG_SVH
`define MLF_CFG_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define MLF_ADDR_SET_A     8'h90
`define MLF_ADDR_SET_B     8'h92
`define MLF_ADDR_IRQ_STAT  8'h94
`define MLF_ADDR_IRQ_MASK  8'h95
`define MLF_ADDR_CTRL      8'h96
`define MLF_ADDR_STATE     8'h97

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MLF_SET_A_RESET    32'h00000000
`define MLF_SET_B_RESET    32'h00000000
`define MLF_MASK_RESET     5'h00

// ----------------------------------------
// Field positions, settings A
// ----------------------------------------
`define MLF_RETRY_MSB      10
`define MLF_RETRY_LSB      7
`define MLF_MODE_MSB       6
`define MLF_MODE_LSB       3
`define MLF_PROBE_TO_BIT   2
`define MLF_PROBE_RATE_BIT 1
`define MLF_SAT_BIT        0

// ----------------------------------------
// Field positions, settings B
// ----------------------------------------
`define MLF_OVS_BIT        30
`define MLF_BEMF_BIT       29
`define MLF_MISS_BIT       28
`define MLF_LIMIT_MSB      2
`define MLF_LIMIT_LSB      0

// ----------------------------------------
// Response codes
// ----------------------------------------
`define MLF_MODE_RETRY_LO  4'h4
`define MLF_MODE_REPORT    4'h8

// ----------------------------------------
// Interrupt bits, control bits
// ----------------------------------------
`define MLF_IRQ_LOCK       0
`define MLF_IRQ_RETRY      1
`define MLF_IRQ_PTO        2
`define MLF_IRQ_PRATE      3
`define MLF_IRQ_SAT        4
`define MLF_IRQ_W          5
`define MLF_CTRL_CLR_BIT   0

// ----------------------------------------
// Timing
// ----------------------------------------
`define MLF_CLK_PERIOD_NS  10
`define MLF_MS_NS          1000000
`define MLF_MS_CYCLES      (`MLF_MS_NS / `MLF_CLK_PERIOD_NS)
`define MLF_RETRY_SHORT_MS 100
`define MLF_RETRY_MID_MS   500
`define MLF_RETRY_STEP_MS  1000

`endif

// file: logic/mlf_pkg.sv
// Purpose: Types shared by the lock fault response logic
// Assumes: Nothing
// Notes:   Constants live in mlf_cfg.svh
package mlf_pkg;

	typedef enum logic [2:0]
	{
		MLF_STG_NORMAL,
		MLF_STG_TRISTATE,
		MLF_STG_RECIRC,
		MLF_STG_HS_BRAKE,
		MLF_STG_LS_BRAKE
	} mlf_stage_e;

	typedef enum logic [1:0]
	{
		MLF_S_IDLE,
		MLF_S_RETRY_WAIT,
		MLF_S_LATCHED,
		MLF_S_REPORT
	} mlf_state_e;

endpackage

// file: logic/mlf_retry_timer.sv
// Purpose: Lock retry interval timer, one done pulse per start that is not aborted
// Assumes: start and abort are single-cycle pulses from core_clk logic
// Notes:   Millisecond prescaler keeps the long intervals cheap
`timescale 1ns/1ns
`include "mlf_cfg.svh"

module mlf_retry_timer
	import mlf_pkg::*;
#(
	parameter int unsigned MS_CYCLES = `MLF_MS_CYCLES
)
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// Control
	input  wire logic       start,
	input  wire logic       abort,
	input  wire logic [3:0] interval_code,
	// Result
	output logic            done
);

	logic        running;
	logic [31:0] pre_cnt;
	logic [13:0] ms_cnt;
	logic [13:0] target;
	wire         ms_tick  = (pre_cnt == 32'(MS_CYCLES - 1));
	wire         last_ms  = (ms_cnt == target - 14'h0001);

	// Interval in milliseconds per code
	function automatic logic [13:0] interval_ms(input logic [3:0] c);
		logic [13:0] v;
		v = 14'h0000;
		case (c)
			4'h0:    v = 14'(`MLF_RETRY_SHORT_MS);
			4'h1:    v = 14'(`MLF_RETRY_MID_MS);
			default: v = 14'((14'(c) - 14'h0001) * 14'(`MLF_RETRY_STEP_MS));
		endcase
		return v;
	endfunction

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			running <= 1'b0;
			pre_cnt <= 32'h00000000;
			ms_cnt  <= 14'h0000;
			target  <= 14'h0000;
			done    <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (abort)
				running <= 1'b0;
			else if (start)
			begin
				running <= 1'b1;
				pre_cnt <= 32'h00000000;
				ms_cnt  <= 14'h0000;
				target  <= interval_ms(interval_code);
			end
			else if (running)
			begin
				pre_cnt <= ms_tick ? 32'h00000000 : pre_cnt + 32'h00000001;
				if (ms_tick && last_ms)
				begin
					running <= 1'b0;
					done    <= 1'b1;
				end
				else if (ms_tick)
					ms_cnt <= ms_cnt + 14'h0001;
			end
		end
	end

endmodule // mlf_retry_timer

// file: logic/mlf_top.sv
// Purpose: Motor lock fault response, probe fault enables, loop flags
// Assumes: Detector and probe inputs come from core_clk logic
// Notes:   Register port answers every read one cycle later
//
// How it works
// - Retry interval field, 4 bits, reset 0: 100 ms, 500 ms, then 1 s steps.
// - Codes 0-3 latch fault, assert indicator, stage tristate/recirc/high/low.
// - Codes 4,5,7 auto-clear after interval, count; past limit latch that stage.
// - Code 6 auto-clears up to limit times with high-side brake, indicator on.
// - Code 8 only reports: indicator asserted, power stage untouched.
// - Codes 9-15 disable lock detection completely.
// - Enable bit, reset 0, makes probe timeout a fault.
// - Enable bit, reset 0, makes probe frequency error a fault.
// - Enable bit, reset 0, turns on loop saturation flags.
// - Second settings register at 0x92, resets to zero.
// - Three enables turn on overspeed, back-EMF and missing-motor detectors.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
`include "mlf_cfg.svh"

module mlf_top
	import mlf_pkg::*;
#(
	parameter int unsigned MS_CYCLES = `MLF_MS_CYCLES
)
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Lock detectors
	input  wire logic        overspeed_detect,
	input  wire logic        low_backemf_detect,
	input  wire logic        missing_load_detect,
	// Rotor position probe events
	input  wire logic        probe_timeout_event,
	input  wire logic        probe_rate_event,
	// Control loop saturation
	input  wire logic        current_loop_sat,
	input  wire logic        speed_loop_sat,
	// Fault outputs
	output logic             fault_indicator_n,
	output mlf_stage_e       stage_sel,
	output logic             probe_fault,
	output logic             current_sat_flag,
	output logic             speed_sat_flag,
	// Interrupt
	output logic             irq
);

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [31:0]          set_a;
	logic [31:0]          set_b;
	logic [`MLF_IRQ_W-1:0] irq_stat;
	logic [`MLF_IRQ_W-1:0] irq_mask;

	// ----------------------------------------
	// Control state
	// ----------------------------------------
	mlf_state_e           state;
	mlf_state_e           next_state;
	mlf_stage_e           next_stage;
	logic [2:0]           retry_cnt;
	logic [2:0]           next_retry;
	logic                 timer_start;
	logic                 timer_done;
	logic                 lock_ev;
	logic                 retry_ev;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire sel_a     = (reg_addr == `MLF_ADDR_SET_A);
	wire sel_b     = (reg_addr == `MLF_ADDR_SET_B);
	wire sel_stat  = (reg_addr == `MLF_ADDR_IRQ_STAT);
	wire sel_mask  = (reg_addr == `MLF_ADDR_IRQ_MASK);
	wire sel_ctrl  = (reg_addr == `MLF_ADDR_CTRL);
	wire sel_state = (reg_addr == `MLF_ADDR_STATE);
	wire wr_a      = reg_wr && sel_a;
	wire wr_b      = reg_wr && sel_b;
	wire wr_stat   = reg_wr && sel_stat;
	wire wr_mask   = reg_wr && sel_mask;
	wire sw_clear  = reg_wr && sel_ctrl && reg_wdata[`MLF_CTRL_CLR_BIT];

	// ----------------------------------------
	// Field extraction
	// ----------------------------------------
	wire [3:0] retry_code  = set_a[`MLF_RETRY_MSB:`MLF_RETRY_LSB];
	wire [3:0] resp_mode   = set_a[`MLF_MODE_MSB:`MLF_MODE_LSB];
	wire       pto_on      = set_a[`MLF_PROBE_TO_BIT];
	wire       prate_on    = set_a[`MLF_PROBE_RATE_BIT];
	wire       sat_on      = set_a[`MLF_SAT_BIT];
	wire       ovs_on      = set_b[`MLF_OVS_BIT];
	wire       bemf_on     = set_b[`MLF_BEMF_BIT];
	wire       miss_on     = set_b[`MLF_MISS_BIT];
	wire [2:0] retry_limit = set_b[`MLF_LIMIT_MSB:`MLF_LIMIT_LSB];

	// ----------------------------------------
	// Lock qualification
	// ----------------------------------------
	wire any_lock = (ovs_on && overspeed_detect)
	             || (bemf_on && low_backemf_detect)
	             || (miss_on && missing_load_detect);
	// Codes above report-only ignore every detector
	wire det_on   = (resp_mode <= `MLF_MODE_REPORT);
	wire lock_hit = any_lock && det_on;
	wire is_latch = (resp_mode < `MLF_MODE_RETRY_LO);
	wire is_retry = !is_latch && (resp_mode < `MLF_MODE_REPORT);
	wire limit_hit = (retry_cnt >= retry_limit);

	// ----------------------------------------
	// Probe and saturation qualification
	// ----------------------------------------
	wire pto_ev   = pto_on && probe_timeout_event;
	wire prate_ev = prate_on && probe_rate_event;
	wire sat_ev   = sat_on && (current_loop_sat || speed_loop_sat);

	// Low two code bits pick the stage for both latch and retry codes
	function automatic mlf_stage_e mode_stage(input logic [3:0] m);
		mlf_stage_e s;
		s = MLF_STG_NORMAL;
		case (m[1:0])
			2'h0:    s = MLF_STG_TRISTATE;
			2'h1:    s = MLF_STG_RECIRC;
			2'h2:    s = MLF_STG_HS_BRAKE;
			default: s = MLF_STG_LS_BRAKE;
		endcase
		return s;
	endfunction

	// ----------------------------------------
	// Response state machine
	// ----------------------------------------
	always_comb
	begin
		next_state  = state;
		next_stage  = stage_sel;
		next_retry  = retry_cnt;
		timer_start = 1'b0;
		lock_ev     = 1'b0;
		retry_ev    = 1'b0;
		if (sw_clear)
		begin
			next_state = MLF_S_IDLE;
			next_stage = MLF_STG_NORMAL;
			next_retry = 3'h0;
		end
		else
		begin
			case (state)
				MLF_S_IDLE:
				begin
					if (lock_hit)
					begin
						lock_ev = 1'b1;
						if (is_latch)
						begin
							next_state = MLF_S_LATCHED;
							next_stage = mode_stage(resp_mode);
						end
						else if (is_retry && limit_hit)
						begin
							next_state = MLF_S_LATCHED;
							next_stage = mode_stage(resp_mode);
						end
						else if (is_retry)
						begin
							next_state  = MLF_S_RETRY_WAIT;
							next_stage  = mode_stage(resp_mode);
							timer_start = 1'b1;
						end
						else
						begin
							next_state = MLF_S_REPORT;
							next_stage = MLF_STG_NORMAL;
						end
					end
				end
				MLF_S_RETRY_WAIT:
				begin
					if (timer_done)
					begin
						next_state = MLF_S_IDLE;
						next_stage = MLF_STG_NORMAL;
						next_retry = retry_cnt + 3'h1;
						retry_ev   = 1'b1;
					end
				end
				MLF_S_LATCHED:
					next_state = MLF_S_LATCHED;
				MLF_S_REPORT:
					next_state = MLF_S_REPORT;
				default:
				begin
					next_state = MLF_S_IDLE;
					next_stage = MLF_STG_NORMAL;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Retry interval timer
	// ----------------------------------------
	mlf_retry_timer #(
		.MS_CYCLES     (MS_CYCLES)
	) u_timer (
		.core_clk      (core_clk),
		.rst_b         (rst_b),
		.start         (timer_start),
		.abort         (sw_clear),
		.interval_code (retry_code),
		.done          (timer_done)
	);

	// ----------------------------------------
	// Event collection
	// ----------------------------------------
	wire [`MLF_IRQ_W-1:0] irq_set;
	wire [`MLF_IRQ_W-1:0] irq_w1c = wr_stat ? reg_wdata[`MLF_IRQ_W-1:0] : '0;
	assign irq_set[`MLF_IRQ_LOCK]  = lock_ev;
	assign irq_set[`MLF_IRQ_RETRY] = retry_ev;
	assign irq_set[`MLF_IRQ_PTO]   = pto_ev;
	assign irq_set[`MLF_IRQ_PRATE] = prate_ev;
	assign irq_set[`MLF_IRQ_SAT]   = sat_ev;
	// Set beats the write-one clear so no event is lost
	wire [`MLF_IRQ_W-1:0] next_stat = (irq_stat & ~irq_w1c) | irq_set;
	wire next_probe = (probe_fault && !sw_clear) || pto_ev || prate_ev;
	wire next_fault = (next_state != MLF_S_IDLE) || next_probe;

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	wire [31:0] state_word = {21'h000000, stage_sel, 1'b0, retry_cnt,
	                          !fault_indicator_n, probe_fault, state};
	wire [31:0] rd_mux = sel_a     ? set_a
	                   : sel_b     ? set_b
	                   : sel_stat  ? {27'h0000000, irq_stat}
	                   : sel_mask  ? {27'h0000000, irq_mask}
	                   : sel_state ? state_word
	                   : 32'h00000000;

	// ----------------------------------------
	// Settings registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			set_a <= `MLF_SET_A_RESET;
			set_b <= `MLF_SET_B_RESET;
		end
		else
		begin
			if (wr_a)
				set_a <= reg_wdata;
			if (wr_b)
				set_b <= reg_wdata;
		end
	end

	// ----------------------------------------
	// Interrupt registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq_stat <= '0;
			irq_mask <= `MLF_MASK_RESET;
			irq      <= 1'b0;
		end
		else
		begin
			irq_stat <= next_stat;
			if (wr_mask)
				irq_mask <= reg_wdata[`MLF_IRQ_W-1:0];
			irq <= |(next_stat & (wr_mask ? reg_wdata[`MLF_IRQ_W-1:0] : irq_mask));
		end
	end

	// ----------------------------------------
	// Response state and outputs
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state             <= MLF_S_IDLE;
			stage_sel         <= MLF_STG_NORMAL;
			retry_cnt         <= 3'h0;
			fault_indicator_n <= 1'b1;
			probe_fault       <= 1'b0;
		end
		else
		begin
			state             <= next_state;
			stage_sel         <= next_stage;
			retry_cnt         <= next_retry;
			fault_indicator_n <= !next_fault;
			probe_fault       <= next_probe;
		end
	end

	// ----------------------------------------
	// Saturation flags and read data
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			current_sat_flag <= 1'b0;
			speed_sat_flag   <= 1'b0;
			reg_rdata        <= 32'h00000000;
		end
		else
		begin
			current_sat_flag <= sat_on && current_loop_sat;
			speed_sat_flag   <= sat_on && speed_loop_sat;
			reg_rdata        <= reg_rd ? rd_mux : 32'h00000000;
		end
	end

endmodule // mlf_top

// file: verif/mlf_top_sva.sv
// Purpose: Port checker for the lock fault response top
// Assumes: One core_clk domain, rst_b active low
// Notes:   Bound into mlf_top below the module
`timescale 1ns/1ns
module mlf_top_sva
	import mlf_pkg::*;
#(
	parameter int unsigned MS_CYCLES = 10
)
(
	// Clock, reset, read port
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Event inputs
	input wire logic        overspeed_detect,
	input wire logic        low_backemf_detect,
	input wire logic        missing_load_detect,
	input wire logic        probe_timeout_event,
	input wire logic        probe_rate_event,
	input wire logic        current_loop_sat,
	input wire logic        speed_loop_sat,
	// Outputs
	input wire logic        fault_indicator_n,
	input wire mlf_stage_e  stage_sel,
	input wire logic        probe_fault,
	input wire logic        current_sat_flag,
	input wire logic        speed_sat_flag,
	input wire logic        irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire logic lock_in = overspeed_detect | low_backemf_detect | missing_load_detect;
	wire logic any_ev  = lock_in | probe_timeout_event | probe_rate_event;
	wire logic hit     = stage_sel != MLF_STG_NORMAL;

	a_rdata_quiet: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
		else $error("read data without a read");
	a_cur_sat_gate: assert property (current_sat_flag |-> $past(current_loop_sat))
		else $error("current flag without saturation");
	a_spd_sat_gate: assert property (speed_sat_flag |-> $past(speed_loop_sat))
		else $error("speed flag without saturation");
	a_stage_flags_fault: assert property (hit |-> !fault_indicator_n)
		else $error("stage held without fault indication");
	a_stage_holds: assert property (hit && $past(hit) |-> stage_sel == $past(stage_sel))
		else $error("stage changed while held");
	a_stage_cause: assert property (hit && !$past(hit) |-> $past(lock_in))
		else $error("stage left normal without a lock");
	a_probe_cause: assert property ($rose(probe_fault) |->
		$past(probe_timeout_event | probe_rate_event))
		else $error("probe fault without a probe event");
	a_fault_cause: assert property ($fell(fault_indicator_n) |->
		$past(any_ev) || $past(any_ev, 2))
		else $error("fault indicated without an event");
	a_release_normal: assert property ($rose(fault_indicator_n) |-> !hit)
		else $error("fault released with stage held");

	c_fault: cover property ($fell(fault_indicator_n));
	c_auto_clear: cover property (hit ##1 !hit);
	c_irq: cover property ($rose(irq));
	c_probe: cover property ($rose(probe_fault));
endmodule // mlf_top_sva

bind mlf_top mlf_top_sva #(.MS_CYCLES(MS_CYCLES)) mlf_top_sva_i (.core_clk(core_clk),
	.rst_b(rst_b), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.overspeed_detect(overspeed_detect), .low_backemf_detect(low_backemf_detect),
	.missing_load_detect(missing_load_detect), .probe_timeout_event(probe_timeout_event),
	.probe_rate_event(probe_rate_event), .current_loop_sat(current_loop_sat),
	.speed_loop_sat(speed_loop_sat), .fault_indicator_n(fault_indicator_n),
	.stage_sel(stage_sel), .probe_fault(probe_fault), .current_sat_flag(current_sat_flag),
	.speed_sat_flag(speed_sat_flag), .irq(irq));

// file: verif/tb.sv
// Purpose: Self-checking bench for the lock fault response top
// Assumes: MS_CYCLES of 10, so 100 ms lasts 1000 cycles
// Notes:   Read results are checked from a queue by a monitor
`timescale 1ns/1ns
`include "mlf_cfg.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb
	import mlf_pkg::*;
;
	localparam int unsigned MSC = 10;
	logic core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, rd_seen = 0;
	logic pto = 0, prt = 0, csat = 0, ssat = 0;
	logic [2:0] det = 3'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, rnd = 32'h801F5270, want, got;
	logic [31:0] exp_q[$], msk_q[$];
	logic [7:0] at[4] = '{8'h90, 8'h92, 8'h10, 8'h96};
	int md_t[3] = '{4, 6, 7};
	wire logic [31:0] reg_rdata;
	wire logic fault_indicator_n, probe_fault, current_sat_flag, speed_sat_flag, irq;
	mlf_stage_e stage_sel;
	int err_total = 0, total_checks = 0, n, len;

	mlf_top #(.MS_CYCLES(MSC)) mlf_top_i (.core_clk(core_clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .overspeed_detect(det[0]), .low_backemf_detect(det[1]),
		.missing_load_detect(det[2]), .probe_timeout_event(pto), .probe_rate_event(prt),
		.current_loop_sat(csat), .speed_loop_sat(ssat), .fault_indicator_n(fault_indicator_n),
		.stage_sel(stage_sel), .probe_fault(probe_fault), .current_sat_flag(current_sat_flag),
		.speed_sat_flag(speed_sat_flag), .irq(irq));

	initial forever #5 core_clk = ~core_clk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [31:0] cfg(input int rc, input int md);
		return (rc << `MLF_RETRY_LSB) | (md << `MLF_MODE_LSB);
	endfunction
	// Codes 0-7 share one pattern: low two bits pick the stage
	function automatic mlf_stage_e stg(input int md);
		return mlf_stage_e'(md % 4 + 1);
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask
	task automatic lk(input int i);
		@(posedge core_clk);
		det <= 3'h1 << i;
		@(posedge core_clk);
		det <= 3'h0;
		cyc(2);
	endtask
	task automatic ev(input logic [1:0] p);
		@(posedge core_clk);
		{pto, prt} <= p;
		@(posedge core_clk);
		{pto, prt} <= 2'b00;
		cyc(2);
	endtask
	task automatic pc(input mlf_stage_e s, input logic f);
		`CHK(stage_sel, s)
		`CHK(fault_indicator_n, f)
	endtask
	task automatic clr();
		wr(`MLF_ADDR_CTRL, 32'h1);
		cyc(1);
	endtask
	task automatic wt(input mlf_stage_e s, input int lim);
		n = 0;
		while (stage_sel !== s)
		begin
			cyc(1);
			n++;
			if (n > lim)
			begin
				err_total++;
				$display("unexpected at %0t: wait ran out", $time);
				tally_and_finish();
			end
		end
	endtask

	always @(posedge core_clk)
	begin
		if (rd_seen)
		begin
			want = exp_q.pop_front();
			got = reg_rdata & msk_q.pop_front();
			`CHK(got, want)
		end
		rd_seen <= reg_rd;
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		rd(`MLF_ADDR_SET_A, 0, '1);
		rd(`MLF_ADDR_SET_B, 0, '1);
		for (int i = 0; i < 4; i++)
		begin
			rnd = lfsr(rnd);
			wr(at[i], rnd);
			rd(at[i], i < 2 ? rnd : 0, '1);
		end
		wr(`MLF_ADDR_SET_A, 0);
		wr(`MLF_ADDR_SET_B, 0);
		clr();
		for (int i = 0; i < 3; i++)
		begin
			lk(i);
			pc(MLF_STG_NORMAL, 1'b1);
		end
		wr(`MLF_ADDR_SET_B, 32'h70000000);
		for (int md = 9; md < 16; md++)
		begin
			wr(`MLF_ADDR_SET_A, cfg(0, md));
			lk(md % 3);
			pc(MLF_STG_NORMAL, 1'b1);
		end
		for (int md = 0; md < 8; md++)
		begin
			wr(`MLF_ADDR_SET_A, cfg(0, md));
			lk(md % 3);
			pc(stg(md), 1'b0);
			rd(`MLF_ADDR_STATE, 32'h2, 32'h3);
			cyc(20);
			pc(stg(md), 1'b0);
			clr();
			pc(MLF_STG_NORMAL, 1'b1);
		end
		wr(`MLF_ADDR_SET_A, cfg(0, 8));
		lk(1);
		pc(MLF_STG_NORMAL, 1'b0);
		rd(`MLF_ADDR_STATE, 32'h3, 32'h3);
		clr();
		pc(MLF_STG_NORMAL, 1'b1);
		wr(`MLF_ADDR_SET_B, 32'h70000001);
		wr(`MLF_ADDR_IRQ_MASK, 32'h2);
		for (int j = 0; j < 3; j++)
		begin
			len = (j == 0 ? 100 : j == 1 ? 500 : 1000) * MSC;
			wr(`MLF_ADDR_SET_A, cfg(j, md_t[j]));
			lk(j);
			pc(stg(md_t[j]), 1'b0);
			`CHK(irq, 1'b0)
			wt(MLF_STG_NORMAL, len + 20);
			`CHK(n >= len - 4 && n <= len + 2, 1'b1)
			pc(MLF_STG_NORMAL, 1'b1);
			cyc(1);
			`CHK(irq, 1'b1)
			rd(`MLF_ADDR_STATE, 32'h10, 32'h70);
			lk(j);
			pc(stg(md_t[j]), 1'b0);
			cyc(len + 10);
			pc(stg(md_t[j]), 1'b0);
			rd(`MLF_ADDR_IRQ_STAT, 32'h3, 32'h3);
			wr(`MLF_ADDR_IRQ_STAT, 32'h1F);
			clr();
			`CHK(irq, 1'b0)
			pc(MLF_STG_NORMAL, 1'b1);
			rd(`MLF_ADDR_STATE, 32'h0, 32'h70);
		end
		wr(`MLF_ADDR_SET_A, 0);
		ev(2'b11);
		`CHK(probe_fault, 1'b0)
		for (int b = 0; b < 2; b++)
		begin
			wr(`MLF_ADDR_SET_A, b ? 32'h2 : 32'h4);
			ev(b ? 2'b10 : 2'b01);
			`CHK(probe_fault, 1'b0)
			ev(b ? 2'b01 : 2'b10);
			`CHK(probe_fault, 1'b1)
			`CHK(fault_indicator_n, 1'b0)
			clr();
			`CHK(probe_fault, 1'b0)
		end
		for (int e = 0; e < 2; e++)
		begin
			wr(`MLF_ADDR_SET_A, e);
			repeat (20)
			begin
				@(posedge core_clk);
				rnd = lfsr(rnd);
				{csat, ssat} <= rnd[1:0];
				cyc(1);
				`CHK({current_sat_flag, speed_sat_flag}, rnd[1:0] & {2{e[0]}})
			end
		end
		// Probe and saturation events must have left their sticky bits
		wr(`MLF_ADDR_SET_A, 0);
		rd(`MLF_ADDR_IRQ_STAT, 32'h1C, 32'h1C);
		wr(`MLF_ADDR_IRQ_MASK, 32'h10);
		cyc(1);
		`CHK(irq, 1'b1)
		wr(`MLF_ADDR_IRQ_STAT, 32'h10);
		cyc(1);
		`CHK(irq, 1'b0)
		// Mid-run reset must drop a counted retry and all settings
		wr(`MLF_ADDR_SET_A, cfg(0, 4));
		lk(0);
		wt(MLF_STG_NORMAL, 1100);
		rd(`MLF_ADDR_STATE, 32'h10, 32'h70);
		@(posedge core_clk);
		rst_b <= 1'b0;
		cyc(2);
		pc(MLF_STG_NORMAL, 1'b1);
		`CHK(irq, 1'b0)
		@(posedge core_clk);
		rst_b <= 1'b1;
		rd(`MLF_ADDR_STATE, 32'h0, 32'h7F);
		rd(`MLF_ADDR_SET_A, 32'h0, '1);
		rd(`MLF_ADDR_SET_B, 32'h0, '1);
		cyc(3);
		tally_and_finish();
	end
endmodule // tb
